// file: shared/bpm_csr_map.svh
// offsets, field positions, reset values and timing counts of the power management csr
`ifndef BPM_CSR_MAP_SVH
`define BPM_CSR_MAP_SVH

// register bus geometry
`define BPM_ADDR_W          8
`define BPM_DATA_W          32

// byte offsets
`define BPM_OFF_POWER_STATE_CTRL_STATUS       8'h94
`define BPM_OFF_INT_STAT    8'hC0
`define BPM_OFF_INT_MASK    8'hC4

// power state field
`define BPM_PS_MSB          1
`define BPM_PS_LSB          0
`define BPM_PS_D0           2'h0
`define BPM_PS_D1           2'h1
`define BPM_PS_D2           2'h2
`define BPM_PS_D3           2'h3
`define BPM_PS_RST          2'h0

// single-bit fields of the power management word
`define BPM_BIT_RSVD2       2
`define BPM_BIT_NO_SOFT_RST 3
`define BPM_BIT_PME_EN      8
`define BPM_BIT_PME_ST      15
`define BPM_BIT_B2B3        22
`define BPM_BIT_BPCC        23

// multi-bit read-as-zero fields
`define BPM_RSVD_LO_MSB     7
`define BPM_RSVD_LO_LSB     4
`define BPM_DSEL_MSB        12
`define BPM_DSEL_LSB        9
`define BPM_DSCALE_MSB      14
`define BPM_DSCALE_LSB      13
`define BPM_RSVD_HI_MSB     21
`define BPM_RSVD_HI_LSB     16
`define BPM_DATA_MSB        31
`define BPM_DATA_LSB        24

// fixed and reset values
`define BPM_NO_SOFT_RST_VAL 1'h1
`define BPM_B2B3_VAL        1'h0
`define BPM_BPCC_VAL        1'h0
`define BPM_PME_EN_RST      1'h0
`define BPM_PME_ST_RST      1'h0

// interrupt status and mask bits
`define BPM_N_EVT           3
`define BPM_EVT_PME         0
`define BPM_EVT_SRST_DONE   1
`define BPM_EVT_PS_DISCARD  2
`define BPM_INT_RST         3'h0

// internal reset pulse
`define BPM_CLK_NS          50
`define BPM_SRST_NS         200
`define BPM_SRST_CYC        ((`BPM_SRST_NS + `BPM_CLK_NS - 1) / `BPM_CLK_NS)
`define BPM_SRST_CNT_W      3

`endif

// file: shared/bpm_pkg.sv
// types of the power management csr
`default_nettype none

package bpm_pkg;

  `include "bpm_csr_map.svh"

  typedef logic [`BPM_ADDR_W-1:0] bpm_addr_t;
  typedef logic [`BPM_DATA_W-1:0] bpm_data_t;
  typedef logic [1:0]             bpm_pstate_t;
  typedef logic [`BPM_N_EVT-1:0]  bpm_evt_t;
  typedef logic [`BPM_SRST_CNT_W-1:0] bpm_cnt_t;

  typedef enum logic {
    BPM_SRST_IDLE,
    BPM_SRST_PULSE
  } bpm_srst_e;

endpackage : bpm_pkg

`default_nettype wire

// file: shared/bpm_csr_if.sv
// decoded register strobes passed from the bus decoder to the register bank
`default_nettype none

interface bpm_csr_if;
  import bpm_pkg::*;

  logic      wr_pm;
  logic      wr_stat;
  logic      wr_mask;
  logic      rd_pm;
  logic      rd_stat;
  logic      rd_mask;
  bpm_data_t wdata;

  modport dec  (output wr_pm, wr_stat, wr_mask, rd_pm, rd_stat, rd_mask, wdata);
  modport regs (input  wr_pm, wr_stat, wr_mask, rd_pm, rd_stat, rd_mask, wdata);

endinterface : bpm_csr_if

`default_nettype wire

// file: src/bpm_bus_decode.sv
// address decode of the plain register port
`default_nettype none

`include "bpm_csr_map.svh"

module bpm_bus_decode
  import bpm_pkg::*;
(
  // register port
  input  wire bpm_pkg::bpm_addr_t addr,
  input  wire bpm_pkg::bpm_data_t wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  // decoded strobes
  bpm_csr_if.dec                  csr
);

  wire hit_pm   = (addr == `BPM_OFF_POWER_STATE_CTRL_STATUS);
  wire hit_stat = (addr == `BPM_OFF_INT_STAT);
  wire hit_mask = (addr == `BPM_OFF_INT_MASK);

  assign csr.wr_pm   = wr_en & hit_pm;
  assign csr.wr_stat = wr_en & hit_stat;
  assign csr.wr_mask = wr_en & hit_mask;
  assign csr.rd_pm   = rd_en & hit_pm;
  assign csr.rd_stat = rd_en & hit_stat;
  assign csr.rd_mask = rd_en & hit_mask;
  assign csr.wdata   = wdata;

endmodule : bpm_bus_decode

`default_nettype wire

// file: src/bpm_csr_top.sv
// power management control and status registers of the bridge
//
// Summary of operation
// - two-bit power state field, reset 00; 00 is D0, 11 is D3
// - writes of codes 01 or 10 are discarded, state kept
// - D3 to D0 by register write pulses internal reset, bus reset untouched
// - no-soft-reset bit is read-only and always reads one
// - sticky event-enable bit, reset 0; event output blocked while it is 0
// - data select, data scale and data byte read zero; writes ignored
// - B2/B3 support bit is read-only zero
// - bus power/clock control bit is read-only zero
//
// Local design decision: the address-and-strobe port.
`default_nettype none

`include "bpm_csr_map.svh"

module bpm_csr_top
  import bpm_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // register port
  input  wire bpm_pkg::bpm_addr_t addr,
  input  wire bpm_pkg::bpm_data_t wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output var  bpm_pkg::bpm_data_t rdata,
  // power management pins
  input  wire logic               pm_wake,
  output var  logic               pm_event_n,
  // to the rest of the bridge
  output var  logic               soft_reset,
  output var  logic               d3_active,
  // interrupt
  output var  logic               irq
);

  import bpm_pkg::*;

  // reset release
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // decoder
  bpm_csr_if csr ();

  bpm_bus_decode u_dec (
    .addr  (addr),
    .wdata (wdata),
    .wr_en (wr_en),
    .rd_en (rd_en),
    .csr   (csr)
  );

  // wake pin synchroniser and edge detect
  logic wake_meta;
  logic wake_sync;
  logic wake_prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= pm_wake;
      wake_sync <= wake_meta;
    end
  end

  // edge flop resets to the idle low level, so no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_prev <= 1'b0;
    end else begin
      wake_prev <= wake_sync;
    end
  end

  wire wake_rise = wake_sync & ~wake_prev;

  // power state
  bpm_pstate_t power_state;
  bpm_pstate_t next_power_state;

  wire bpm_pstate_t ps_wdata = csr.wdata[`BPM_PS_MSB:`BPM_PS_LSB];
  // only D0 and D3 exist; any other code leaves the state alone
  wire ps_legal    = (ps_wdata == `BPM_PS_D0) | (ps_wdata == `BPM_PS_D3);
  wire ps_take     = csr.wr_pm & ps_legal;
  wire ps_discard  = csr.wr_pm & ~ps_legal;
  wire leave_d3    = ps_take & (power_state == `BPM_PS_D3) & (ps_wdata == `BPM_PS_D0);

  assign next_power_state = ps_take ? ps_wdata : power_state;

  // state flag for the rest of the bridge, registered with the state itself
  logic next_d3_active;

  assign next_d3_active = (next_power_state == `BPM_PS_D3);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= `BPM_PS_RST;
    end else begin
      power_state <= next_power_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d3_active <= 1'b0;
    end else begin
      d3_active <= next_d3_active;
    end
  end

  // event enable and event status, kept over the internal reset
  logic pme_en;
  logic pme_status;
  logic next_pme_en;
  logic next_pme_status;

  wire pme_clear = csr.wr_pm & csr.wdata[`BPM_BIT_PME_ST];

  assign next_pme_en     = csr.wr_pm ? csr.wdata[`BPM_BIT_PME_EN] : pme_en;
  assign next_pme_status = wake_rise | (pme_status & ~pme_clear);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_en <= `BPM_PME_EN_RST;
    end else begin
      pme_en <= next_pme_en;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_status <= `BPM_PME_ST_RST;
    end else begin
      pme_status <= next_pme_status;
    end
  end

  // active-low event pin follows the status and enable as they will stand
  logic next_pm_event_n;

  assign next_pm_event_n = ~(next_pme_status & next_pme_en);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_event_n <= 1'b1;
    end else begin
      pm_event_n <= next_pm_event_n;
    end
  end

  // internal reset pulse on the D3 to D0 step
  bpm_srst_e srst_state;
  bpm_srst_e next_srst_state;
  bpm_cnt_t  srst_cnt;
  bpm_cnt_t  next_srst_cnt;

  localparam bpm_cnt_t SRST_LAST = bpm_cnt_t'(`BPM_SRST_CYC - 1);

  // done only when the pulse truly ends; a restart in its last cycle holds it off
  wire srst_done = (srst_state == BPM_SRST_PULSE) & (srst_cnt == SRST_LAST) & ~leave_d3;

  always_comb begin
    next_srst_state = srst_state;
    next_srst_cnt   = srst_cnt;
    unique case (srst_state)
      BPM_SRST_IDLE: begin
        if (leave_d3) begin
          next_srst_state = BPM_SRST_PULSE;
          next_srst_cnt   = '0;
        end
      end
      BPM_SRST_PULSE: begin
        if (leave_d3) begin
          next_srst_cnt = '0;
        end else if (srst_cnt == SRST_LAST) begin
          next_srst_state = BPM_SRST_IDLE;
          next_srst_cnt   = '0;
        end else begin
          next_srst_cnt = bpm_cnt_t'(srst_cnt + 1'b1);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_state <= BPM_SRST_IDLE;
      srst_cnt   <= '0;
    end else begin
      srst_state <= next_srst_state;
      srst_cnt   <= next_srst_cnt;
    end
  end

  // pulse to the bridge only; the bus reset pin is never touched here
  logic next_soft_reset;

  assign next_soft_reset = (next_srst_state == BPM_SRST_PULSE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= next_soft_reset;
    end
  end

  // interrupt status and mask
  bpm_evt_t int_stat;
  bpm_evt_t int_mask;
  bpm_evt_t next_int_stat;
  bpm_evt_t evt;

  assign evt[`BPM_EVT_PME]        = wake_rise;
  assign evt[`BPM_EVT_SRST_DONE]  = srst_done;
  assign evt[`BPM_EVT_PS_DISCARD] = ps_discard;

  genvar gi;
  generate
    for (gi = 0; gi < `BPM_N_EVT; gi++) begin : g_stat
      // a new event beats a clear in the same cycle
      assign next_int_stat[gi] = evt[gi] | (int_stat[gi] & ~(csr.wr_stat & csr.wdata[gi]));
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= `BPM_INT_RST;
    end else begin
      int_stat <= next_int_stat;
    end
  end

  bpm_evt_t next_int_mask;
  logic     next_irq;

  assign next_int_mask = csr.wr_mask ? csr.wdata[`BPM_N_EVT-1:0] : int_mask;
  assign next_irq      = |(next_int_stat & next_int_mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= `BPM_INT_RST;
    end else begin
      int_mask <= next_int_mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // power management word as read; config here survives the internal reset,
  // so the no-soft-reset bit truthfully reads one
  bpm_data_t pm_word;

  always_comb begin
    pm_word                                    = '0;
    pm_word[`BPM_PS_MSB:`BPM_PS_LSB]           = power_state;
    pm_word[`BPM_BIT_RSVD2]                    = 1'b0;
    pm_word[`BPM_BIT_NO_SOFT_RST]              = `BPM_NO_SOFT_RST_VAL;
    pm_word[`BPM_RSVD_LO_MSB:`BPM_RSVD_LO_LSB] = 4'h0;
    pm_word[`BPM_BIT_PME_EN]                   = pme_en;
    pm_word[`BPM_DSEL_MSB:`BPM_DSEL_LSB]       = 4'h0;
    pm_word[`BPM_DSCALE_MSB:`BPM_DSCALE_LSB]   = 2'h0;
    pm_word[`BPM_BIT_PME_ST]                   = pme_status;
    pm_word[`BPM_RSVD_HI_MSB:`BPM_RSVD_HI_LSB] = 6'h00;
    pm_word[`BPM_BIT_B2B3]                     = `BPM_B2B3_VAL;
    pm_word[`BPM_BIT_BPCC]                     = `BPM_BPCC_VAL;
    pm_word[`BPM_DATA_MSB:`BPM_DATA_LSB]       = 8'h00;
  end

  // read mux; unmapped or idle gives zero
  wire bpm_data_t stat_word = {{(`BPM_DATA_W-`BPM_N_EVT){1'b0}}, int_stat};
  wire bpm_data_t mask_word = {{(`BPM_DATA_W-`BPM_N_EVT){1'b0}}, int_mask};
  wire bpm_data_t rd_word   = csr.rd_pm   ? pm_word   :
                              csr.rd_stat ? stat_word :
                              csr.rd_mask ? mask_word : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd_word;
    end
  end

endmodule : bpm_csr_top

`default_nettype wire

// file: bench/bpm_csr_properties.sv
// port assertions of the power management csr
`default_nettype none

module bpm_csr_properties
  import bpm_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire bpm_pkg::bpm_addr_t addr,
  input wire bpm_pkg::bpm_data_t wdata,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire bpm_pkg::bpm_data_t rdata,
  input wire logic               pm_event_n,
  input wire logic               soft_reset,
  input wire logic               d3_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_d3_to_d0;
    wr_en && addr == 8'h94 && wdata[1:0] == 2'h0 && d3_active;
  endsequence
  sequence s_pm_rd;
    $past(rd_en) && $past(addr) == 8'h94;
  endsequence

  a_ps_d3_set: assert property (wr_en && addr == 8'h94 && wdata[1:0] == 2'h3 |=> d3_active)
    else $error("d3 not entered");
  a_ps_discard: assert property (wr_en && addr == 8'h94 && ^wdata[1:0] |=> $stable(d3_active))
    else $error("bad state kept");
  a_srst_pulse: assert property (s_d3_to_d0 |=> soft_reset [*4])
    else $error("reset pulse short");
  a_nsr_bit: assert property (s_pm_rd |-> rdata[3])
    else $error("no soft reset bit");
  a_en_blocks: assert property (wr_en && addr == 8'h94 && !wdata[8] |=> pm_event_n)
    else $error("event not blocked");
  a_data_zero: assert property (s_pm_rd |-> rdata[14:9] == 6'h00 && rdata[31:24] == 8'h00)
    else $error("data fields set");
  a_bus_bits: assert property (s_pm_rd |-> rdata[23:22] == 2'h0)
    else $error("bus bits set");
  a_evt_pair: assert property (s_pm_rd |-> (rdata[8] && rdata[15]) == !$past(pm_event_n))
    else $error("event output wrong");
endmodule : bpm_csr_properties

bind bpm_csr_top bpm_csr_properties chk_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pm_event_n(pm_event_n), .soft_reset(soft_reset),
  .d3_active(d3_active));

`default_nettype wire

// file: bench/bpm_host.sv
// host model issuing register reads and writes
`default_nettype none

module bpm_host
  import bpm_pkg::*;
(
  input  wire logic               clk,
  output var  bpm_pkg::bpm_addr_t addr,
  output var  bpm_pkg::bpm_data_t wdata,
  output var  logic               wr_en,
  output var  logic               rd_en,
  input  wire bpm_pkg::bpm_data_t rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  task wr(input bpm_addr_t a, input bpm_data_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // data only stand in the cycle after the strobe
  task rd(input bpm_addr_t a, output bpm_data_t v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
endmodule : bpm_host

`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench of the power management csr
`default_nettype none

module tb_top import bpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic      clk;
  logic      rst_b;
  logic      wr_en;
  logic      rd_en;
  logic      pm_wake;
  logic      pm_event_n;
  logic      soft_reset;
  logic      d3_active;
  logic      irq;
  bpm_addr_t addr;
  bpm_data_t wdata;
  bpm_data_t rdata;
  bpm_data_t d;
  int        err_count;
  int        compares;
  int        n;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  bpm_csr_top dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pm_wake(pm_wake), .pm_event_n(pm_event_n), .soft_reset(soft_reset),
    .d3_active(d3_active), .irq(irq));
  bpm_host host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

  task check(input bpm_data_t seen, input bpm_data_t exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task rchk(input bpm_addr_t a, input bpm_data_t exp);
    host_u.rd(a, d);
    check(d, exp);
  endtask : rchk

  task settle;
    @(posedge clk);
    #1;
  endtask : settle

  task drive_wake(input logic v);
    @(posedge clk);
    pm_wake <= v;
  endtask : drive_wake

  task print_verdict;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial begin
    #50us;
    err_count++;
    print_verdict();
  end

  initial begin
    err_count = 0;
    compares = 0;
    rst_b = 1'b0;
    pm_wake = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(8'h94, 32'h0000_0008);
    host_u.wr(8'h94, 32'hFFFF_FFFF);
    rchk(8'h94, 32'h0000_010B);
    check({31'h0, d3_active}, 32'h1);
    host_u.wr(8'h94, 32'h0000_0101);
    host_u.wr(8'h94, 32'h0000_0102);
    rchk(8'h94, 32'h0000_010B);
    rchk(8'h20, 32'h0);
    rchk(8'hC0, 32'h4);
    host_u.wr(8'hC4, 32'h7);
    settle();
    check({31'h0, irq}, 32'h1);
    host_u.wr(8'hC0, 32'h7);
    settle();
    check({31'h0, irq}, 32'h0);
    drive_wake(1'b1);
    n = 0;
    while (pm_event_n !== 1'b0 && n < 10) begin
      settle();
      n++;
    end
    check({31'h0, pm_event_n}, 32'h0);
    host_u.wr(8'h94, 32'h0000_0103);
    rchk(8'h94, 32'h0000_810B);
    host_u.wr(8'h94, 32'h0000_8103);
    rchk(8'h94, 32'h0000_010B);
    check({31'h0, pm_event_n}, 32'h1);
    drive_wake(1'b0);
    host_u.wr(8'hC4, 32'h0);
    settle();
    check({31'h0, irq}, 32'h0);
    host_u.wr(8'hC0, 32'h1);
    host_u.wr(8'h94, 32'h0000_0003);
    drive_wake(1'b1);
    repeat (6) settle();
    check({31'h0, pm_event_n}, 32'h1);
    rchk(8'h94, 32'h0000_800B);
    host_u.wr(8'h94, 32'h0000_0103);
    settle();
    check({31'h0, pm_event_n}, 32'h0);
    drive_wake(1'b0);
    host_u.wr(8'h94, 32'h0000_8000);
    n = 0;
    repeat (8) begin
      #1;
      if (soft_reset === 1'b1)
        n++;
      @(posedge clk);
    end
    check(32'(n), 32'h4);
    check({31'h0, d3_active}, 32'h0);
    rchk(8'h94, 32'h0000_0008);
    rchk(8'hC0, 32'h3);
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
